// ==== acr_pkg.sv ====
package acr_pkg;
   // Register addresses on the serial register port.
   localparam logic [7:0] ACR_ADDR_SWITCH = 8'h0A;
   localparam logic [7:0] ACR_ADDR_DIAG = 8'h0B;
   localparam logic [7:0] ACR_ADDR_OUT = 8'h0C;
   localparam logic [7:0] ACR_ADDR_PAIR = 8'h0D;
   localparam logic [7:0] ACR_ADDR_MISC = 8'h10;
   localparam logic [7:0] ACR_ADDR_THERM = 8'h13;
   // Reset values.
   localparam logic [7:0] ACR_RST_SWITCH = 8'h0D;
   localparam logic [7:0] ACR_RST_DIAG = 8'h50;
   localparam logic [7:0] ACR_RST_OUT = 8'h1F;
   localparam logic [7:0] ACR_RST_PAIR = 8'h00;
   localparam logic [7:0] ACR_RST_MISC = 8'h01;
   // Writable bit masks; reserved positions read zero.
   localparam logic [7:0] ACR_MASK_OUT = 8'hBF;
   localparam logic [7:0] ACR_MASK_PAIR = 8'h3F;
   localparam logic [7:0] ACR_MASK_MISC = 8'hBF;
   // Field positions.
   localparam int ACR_B_FOLDBACK = 7;
   localparam int ACR_B_SYNC_PULSE = 6;
   localparam int ACR_B_PHASE = 5;
   localparam int ACR_B_HARD_STOP = 4;
   localparam int ACR_F_SRC_LSB = 2;
   localparam int ACR_B_CLK_OUT = 7;
   localparam int ACR_B_SLAVE = 6;
   localparam int ACR_B_TW = 5;
   localparam int ACR_B_DC_DIS = 4;
   localparam int ACR_B_RESET = 7;
   localparam int ACR_B_DC_KEEP = 5;
   localparam int ACR_B_UNMUTE = 4;
   localparam int ACR_B_PAIR34 = 5;
   localparam int ACR_B_PAIR12 = 4;
   localparam int ACR_B_SLOWER = 7;
   localparam int ACR_B_TRIPLE = 5;
   localparam int ACR_B_QUAD = 4;
   localparam int ACR_B_GAP = 3;
   localparam int ACR_B_XTALK = 2;
   // Codes.
   localparam logic [1:0] ACR_FREQ_500 = 2'h0;
   localparam logic [1:0] ACR_FREQ_417 = 2'h1;
   localparam logic [1:0] ACR_FREQ_357 = 2'h2;
   localparam logic [1:0] ACR_SRC_TWEETER = 2'h0;
   localparam logic [1:0] ACR_SRC_CLIP = 2'h1;
   localparam logic [1:0] ACR_SRC_WARN = 2'h2;
   localparam logic [1:0] ACR_DC_1V6 = 2'h1;
   localparam logic [1:0] ACR_DC_2V4 = 2'h2;
   // Switching periods in clk cycles at 10 MHz, half period each.
   localparam int ACR_CLK_HZ = 10000000;
   localparam int ACR_F500_HZ = 500000;
   localparam int ACR_F417_HZ = 417000;
   localparam int ACR_F357_HZ = 357000;
   localparam logic [7:0] ACR_HALF_500 = 8'(ACR_CLK_HZ / (2 * ACR_F500_HZ));
   localparam logic [7:0] ACR_HALF_417 = 8'(ACR_CLK_HZ / (2 * ACR_F417_HZ));
   localparam logic [7:0] ACR_HALF_357 = 8'(ACR_CLK_HZ / (2 * ACR_F357_HZ));
   localparam logic [7:0] ACR_ONE8 = 8'h01;
   // Load-probe phase gap.
   localparam int ACR_GAP_MS = 20;
   localparam int ACR_GAP_CYC = ACR_CLK_HZ / 1000 * ACR_GAP_MS;
   typedef enum logic [1:0] {
      ACR_ST_IDLE = 2'b00,
      ACR_ST_RUN = 2'b01,
      ACR_ST_GAP = 2'b10
   } acr_probe_e;
endpackage

// ==== acr_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree.
module acr_sync3 #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Data.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } acr_sync_s;
   acr_sync_s r, next_r;
   always_comb begin
      next_r = r;
      if (ce) begin
         next_r.s1 = d;
         next_r.s2 = r.s1;
         next_r.s3 = r.s2;
         for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
               next_r.q[i] = r.s3[i];
            end
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign q = r.q;
endmodule
`default_nettype wire

// ==== acr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Frequency code 01 417k, 00 500k, 10 357k
// - Indicator source: tweeter, clip, warning, none
// - Bit 7 adds foldback to indicator
// - Sync pulse only when oscillator master
// - Bit 5 anti-phase, bit 4 hard stop
// - Clock drive-out only when oscillator master
// - Slave mode default; external clock needed
// - Tweeter probe enable; DC check disable
// - Bits 3..0 launch channel load probes
// - DC fault flagged; outputs stay on only with keep bit 5 set
// - Unmute bit plays driven channels
// - Mute bits silence channels, outputs driven
// - Pair bits join channels 3-4, 1-2
// - Low-low bits per channel
// - Low-low grounds both output terminals
// - Slower rampdown; triple ramp time
// - Quadruple short-probe phase durations
// - 20 ms gap between probes; crosstalk option
// - DC threshold 01 1.6V, 10 2.4V
// - Thermal status: shutdown high, foldback low
module acr_regs
   import acr_pkg::*;
#(
   parameter int GAP_CYCLES = acr_pkg::ACR_GAP_CYC,
   parameter int PROBE_CYCLES = 1000
) (
   // Clock, enable and reset.
   input wire logic clk,
   input wire logic ce,
   input wire logic reset_n,
   // Register port from the serial bus slave.
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic rvalid,
   // Analog status inputs from pins.
   input wire logic [3:0] overheat_shutdown_in,
   input wire logic [3:0] heat_derating_in,
   input wire logic overtemp_warning_in,
   input wire logic clip_detect_in,
   input wire logic tweeter_detect_in,
   input wire logic [3:0] offset_fault_in,
   input wire logic ext_osc_in,
   // Pins and controls out.
   output logic indicator_report_pin,
   output logic shared_oscillator_pin_o,
   output logic shared_oscillator_pin_oe,
   output logic switch_clk,
   output logic switch_clk_b,
   output logic hard_stop,
   output logic small_speaker_probe_enable,
   output logic offset_check_enable,
   output logic [1:0] offset_threshold_select,
   output logic [3:0] offset_fault_flag,
   output logic [3:0] channel_shutdown,
   output logic [3:0] channel_silence,
   output logic [3:0] channel_play,
   output logic [3:0] channel_grounded,
   output logic pair_first_two_channels,
   output logic pair_last_two_channels,
   output logic extended_midlevel_rampdown,
   output logic triple_midlevel_ramp,
   output logic channel_leak_reduction,
   output logic [3:0] probe_active,
   output logic quadruple_short_probe_time
);
   import acr_pkg::*;
   //////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [7:0] sw;
      logic [7:0] diag;
      logic [7:0] outc;
      logic [7:0] pair;
      logic [7:0] misc;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] div;
      logic osc;
      logic osc_d;
      logic sync_pulse;
      logic [3:0] fault;
      acr_probe_e probe_st;
      logic [1:0] probe_ch;
      logic [31:0] probe_cnt;
      logic ind;
   } acr_regs_s;
   acr_regs_s r, next_r;
   logic rst_n;
   logic [14:0] pins;
   logic [3:0] s_otsd, s_thfb, s_dcf;
   logic s_otw, s_clip, s_tw, s_ext;

   acr_sync3 #(.W(15)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .d({overheat_shutdown_in, heat_derating_in, offset_fault_in,
          overtemp_warning_in, clip_detect_in, tweeter_detect_in}),
      .q(pins)
   );
   assign {s_otsd, s_thfb, s_dcf, s_otw, s_clip, s_tw} = pins;

   acr_sync3 #(.W(1)) u_osc (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .d(ext_osc_in),
      .q(s_ext)
   );
   assign rst_n = r.rst_sync[1];

   function automatic logic [7:0] half_of(input logic [1:0] code);
      case (code)
         ACR_FREQ_500: half_of = ACR_HALF_500;
         ACR_FREQ_357: half_of = ACR_HALF_357;
         default: half_of = ACR_HALF_417;
      endcase
   endfunction

   function automatic logic [7:0] read_of(input acr_regs_s s, input logic [7:0] a, input logic [7:0] st);
      case (a)
         ACR_ADDR_SWITCH: read_of = s.sw;
         ACR_ADDR_DIAG: read_of = s.diag;
         ACR_ADDR_OUT: read_of = s.outc;
         ACR_ADDR_PAIR: read_of = s.pair;
         ACR_ADDR_MISC: read_of = s.misc;
         ACR_ADDR_THERM: read_of = st;
         default: read_of = 8'h00;
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////
   logic master;
   logic [7:0] therm;
   logic [31:0] run_len;
   assign master = ~r.diag[ACR_B_SLAVE];
   assign therm = {s_otsd, s_thfb};
   assign run_len = r.misc[ACR_B_QUAD] ? 32'(PROBE_CYCLES * 4) : 32'(PROBE_CYCLES);

   always_comb begin
      next_r = r;
      next_r.rst_sync = {r.rst_sync[0], 1'b1};
      if (ce) begin
         next_r.rvalid = rd_en;
         if (rd_en) begin
            next_r.rdata = read_of(r, addr, therm);
         end
         if (wr_en) begin
            case (addr)
               ACR_ADDR_SWITCH: begin
                  // A forbidden frequency code is kept out
                  next_r.sw = (wdata[1:0] == 2'h3) ? {wdata[7:2], r.sw[1:0]} : wdata;
               end
               ACR_ADDR_DIAG: next_r.diag = wdata;
               ACR_ADDR_OUT: next_r.outc = wdata & ACR_MASK_OUT;
               ACR_ADDR_PAIR: next_r.pair = wdata & ACR_MASK_PAIR;
               ACR_ADDR_MISC: next_r.misc = wdata & ACR_MASK_MISC;
               default: begin
               end
            endcase
         end
         // Switching clock: own divider as master, external oscillator as slave.
         if (r.div >= half_of(r.sw[1:0]) - ACR_ONE8) begin
            next_r.div = 8'h00;
            next_r.osc = ~r.osc;
         end else begin
            next_r.div = r.div + ACR_ONE8;
         end
         if (!master) begin
            next_r.osc = s_ext;
         end
         next_r.osc_d = r.osc;
         next_r.sync_pulse = master && r.sw[ACR_B_SYNC_PULSE] && r.osc && !r.osc_d;
         // Faults are latched as flags even when shutdown is overridden.
         next_r.fault = r.diag[ACR_B_DC_DIS] ? 4'h0 : (r.fault | s_dcf);
         // Load probe sequencer walks the enabled channels one at a time.
         case (r.probe_st)
            ACR_ST_IDLE: begin
               if (r.diag[r.probe_ch]) begin
                  next_r.probe_st = ACR_ST_RUN;
                  next_r.probe_cnt = 32'h0;
               end else begin
                  next_r.probe_ch = r.probe_ch + 2'h1;
               end
            end
            ACR_ST_RUN: begin
               next_r.probe_cnt = r.probe_cnt + 32'h1;
               if (r.probe_cnt >= run_len - 32'h1) begin
                  next_r.diag[r.probe_ch] = 1'b0;
                  next_r.probe_cnt = 32'h0;
                  next_r.probe_st = r.misc[ACR_B_GAP] ? ACR_ST_GAP : ACR_ST_IDLE;
                  next_r.probe_ch = r.probe_ch + 2'h1;
               end
            end
            ACR_ST_GAP: begin
               next_r.probe_cnt = r.probe_cnt + 32'h1;
               if (r.probe_cnt >= 32'(GAP_CYCLES) - 32'h1) begin
                  next_r.probe_st = ACR_ST_IDLE;
               end
            end
            default: next_r.probe_st = ACR_ST_IDLE;
         endcase
         // Indicator source selection.
         case (r.sw[3:ACR_F_SRC_LSB])
            ACR_SRC_TWEETER: next_r.ind = s_tw;
            ACR_SRC_CLIP: next_r.ind = s_clip;
            ACR_SRC_WARN: next_r.ind = s_otw;
            default: next_r.ind = 1'b0;
         endcase
         if (r.sw[ACR_B_FOLDBACK] && |s_thfb) begin
            next_r.ind = 1'b1;
         end
         // Device reset bit restores every register.
         if (r.outc[ACR_B_RESET]) begin
            next_r.sw = ACR_RST_SWITCH;
            next_r.diag = ACR_RST_DIAG;
            next_r.outc = ACR_RST_OUT;
            next_r.pair = ACR_RST_PAIR;
            next_r.misc = ACR_RST_MISC;
            next_r.fault = 4'h0;
            next_r.probe_st = ACR_ST_IDLE;
            next_r.probe_cnt = 32'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (!rst_n) begin
         r <= '0;
         r.rst_sync <= next_r.rst_sync;
         r.sw <= ACR_RST_SWITCH;
         r.diag <= ACR_RST_DIAG;
         r.outc <= ACR_RST_OUT;
         r.pair <= ACR_RST_PAIR;
         r.misc <= ACR_RST_MISC;
      end else begin
         r <= next_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign rdata = r.rdata;
   assign rvalid = r.rvalid;
   assign indicator_report_pin = r.ind;
   assign shared_oscillator_pin_o = r.diag[ACR_B_CLK_OUT] ? r.osc : r.sync_pulse;
   assign shared_oscillator_pin_oe = master && (r.diag[ACR_B_CLK_OUT] || r.sw[ACR_B_SYNC_PULSE]);
   assign switch_clk = r.osc;
   assign switch_clk_b = r.sw[ACR_B_PHASE] ? ~r.osc : r.osc;
   assign hard_stop = r.sw[ACR_B_HARD_STOP];
   assign small_speaker_probe_enable = r.diag[ACR_B_TW];
   assign offset_check_enable = ~r.diag[ACR_B_DC_DIS];
   assign offset_threshold_select = r.misc[1:0];
   assign offset_fault_flag = r.fault;
   assign channel_shutdown = r.outc[ACR_B_DC_KEEP] ? 4'h0 : r.fault;
   assign channel_silence = r.outc[3:0] & ~r.pair[3:0];
   assign channel_play = r.outc[ACR_B_UNMUTE] ? ~r.outc[3:0] & ~r.pair[3:0] : 4'h0;
   assign channel_grounded = r.pair[3:0];
   assign pair_first_two_channels = r.pair[ACR_B_PAIR12];
   assign pair_last_two_channels = r.pair[ACR_B_PAIR34];
   assign extended_midlevel_rampdown = r.misc[ACR_B_SLOWER];
   assign triple_midlevel_ramp = r.misc[ACR_B_TRIPLE];
   assign channel_leak_reduction = r.misc[ACR_B_XTALK];
   assign quadruple_short_probe_time = r.misc[ACR_B_QUAD];
   assign probe_active = (r.probe_st == ACR_ST_RUN) ? 4'(1 << r.probe_ch) : 4'h0;
endmodule
`default_nettype wire

// ==== acr_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module acr_regs_chk
   import acr_pkg::*;
(
   // Clock, enable and reset.
   input wire logic clk,
   input wire logic ce,
   input wire logic reset_n,
   // Register port.
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   // Controls out.
   input wire logic shared_oscillator_pin_oe,
   input wire logic hard_stop,
   input wire logic small_speaker_probe_enable,
   input wire logic offset_check_enable,
   input wire logic [3:0] channel_silence,
   input wire logic [3:0] channel_play,
   input wire logic [3:0] channel_grounded,
   input wire logic pair_first_two_channels,
   input wire logic pair_last_two_channels,
   input wire logic triple_midlevel_ramp,
   input wire logic channel_leak_reduction
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic wr_ok;
   assign wr_ok = wr_en && ce;
   chk_read_answer: assert property (rd_en && ce |=> rvalid)
      else $error("read not answered next cycle");
   chk_rvalid_cause: assert property (ce && !rd_en |=> !rvalid)
      else $error("read valid without a read");
   chk_unmapped_zero: assert property (rd_en && ce && addr == 8'h0E |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_hard_stop_level: assert property (wr_ok && addr == ACR_ADDR_SWITCH
      |=> hard_stop == $past(wdata[ACR_B_HARD_STOP]))
      else $error("hard stop does not follow write");
   chk_diag_levels: assert property (wr_ok && addr == ACR_ADDR_DIAG |=> offset_check_enable != $past(wdata[4])
      && small_speaker_probe_enable == $past(wdata[5]))
      else $error("probe or offset check level wrong");
   chk_pair_levels: assert property (wr_ok && addr == ACR_ADDR_PAIR |=> channel_grounded == $past(wdata[3:0])
      && pair_last_two_channels == $past(wdata[5]) && pair_first_two_channels == $past(wdata[4]))
      else $error("pairing or grounding level wrong");
   chk_misc_levels: assert property (wr_ok && addr == ACR_ADDR_MISC |=> triple_midlevel_ramp == $past(wdata[5])
      && channel_leak_reduction == $past(wdata[2]))
      else $error("ramp or crosstalk level wrong");
   chk_osc_slave_quiet: assert property (wr_ok && addr == ACR_ADDR_DIAG && wdata[6]
      |=> ##1 !shared_oscillator_pin_oe [*4])
      else $error("oscillator pin driven in slave mode");
   chk_ground_masks: assert property ((channel_grounded & (channel_play | channel_silence)) == 4'h0)
      else $error("grounded channel also muted or playing");
endmodule
bind acr_regs acr_regs_chk u_chk (.clk(clk), .ce(ce), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
   .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .shared_oscillator_pin_oe(shared_oscillator_pin_oe),
   .hard_stop(hard_stop), .small_speaker_probe_enable(small_speaker_probe_enable),
   .offset_check_enable(offset_check_enable), .channel_silence(channel_silence), .channel_play(channel_play),
   .channel_grounded(channel_grounded), .pair_first_two_channels(pair_first_two_channels),
   .pair_last_two_channels(pair_last_two_channels), .triple_midlevel_ramp(triple_midlevel_ramp),
   .channel_leak_reduction(channel_leak_reduction));
`default_nettype wire

// ==== acr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
   // Clock.
   input wire logic clk,
   // Register port.
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   // External oscillator.
   output logic ext_osc_in
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      ext_osc_in = 1'b0;
      forever begin
         repeat (12) @(negedge clk);
         ext_osc_in = ~ext_osc_in;
      end
   end
   // Released bus lines show the inverse of their last value.
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      int i;
      @(negedge clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      addr = ~a;
      for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk);
      d = rvalid === 1'b1 ? rdata : 8'hXX;
   endtask
endmodule
`default_nettype wire

// ==== amp_control_register_bank_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module amp_control_register_bank_bench;
   import acr_pkg::*;
   logic clk = 1'b0, ce = 1'b1, reset_n = 1'b0, wr_en, rd_en, rvalid, ext_osc_in, pin, oe;
   logic clip = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] ovh = 4'h0, der = 4'h0, gnd, pa;
   int n_mismatch = 0, samples_checked = 0;
   initial forever #50 clk = ~clk;
   acr_regs #(.GAP_CYCLES(20), .PROBE_CYCLES(8)) u_dut (.clk(clk), .ce(ce), .reset_n(reset_n), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .overheat_shutdown_in(ovh),
      .heat_derating_in(der), .overtemp_warning_in(1'b0), .clip_detect_in(clip), .tweeter_detect_in(1'b0),
      .offset_fault_in(4'h0), .ext_osc_in(ext_osc_in), .indicator_report_pin(pin), .shared_oscillator_pin_o(),
      .shared_oscillator_pin_oe(oe), .switch_clk(), .switch_clk_b(), .hard_stop(), .small_speaker_probe_enable(),
      .offset_check_enable(), .offset_threshold_select(), .offset_fault_flag(), .channel_shutdown(),
      .channel_silence(), .channel_play(), .channel_grounded(gnd), .pair_first_two_channels(),
      .pair_last_two_channels(), .extended_midlevel_rampdown(), .triple_midlevel_ramp(),
      .channel_leak_reduction(), .probe_active(pa), .quadruple_short_probe_time());
   acr_host_model u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
      .rvalid(rvalid), .ext_osc_in(ext_osc_in));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.read(a, d);
      check(d, exp);
   endtask
   task automatic settle(input logic [3:0] want);
      int i;
      for (i = 0; i < 40 && pa !== want; i++) @(negedge clk);
   endtask
   task automatic give_verdict();
      $display("checked %0d, mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_regs();
      logic [7:0] ra [5] = '{ACR_ADDR_SWITCH, ACR_ADDR_DIAG, ACR_ADDR_OUT, ACR_ADDR_PAIR, ACR_ADDR_MISC};
      logic [7:0] rv [5] = '{8'h0D, 8'h50, 8'h1F, 8'h00, 8'h01};
      for (int i = 0; i < 5; i++) rd_chk(ra[i], rv[i]);
      rd_chk(ACR_ADDR_THERM, 8'h00);
      rd_chk(8'h0E, 8'h00);
      $display("test reset values done");
   endtask
   task automatic t_write_read();
      u_host.write(ACR_ADDR_SWITCH, 8'hFF);
      rd_chk(ACR_ADDR_SWITCH, 8'hFD);
      u_host.write(ACR_ADDR_SWITCH, 8'h72);
      rd_chk(ACR_ADDR_SWITCH, 8'h72);
      u_host.write(ACR_ADDR_OUT, 8'h7F);
      rd_chk(ACR_ADDR_OUT, 8'h3F);
      u_host.write(ACR_ADDR_PAIR, 8'hFF);
      rd_chk(ACR_ADDR_PAIR, 8'h3F);
      check({4'h0, gnd}, 8'h0F);
      u_host.write(ACR_ADDR_MISC, 8'hFF);
      rd_chk(ACR_ADDR_MISC, 8'hBF);
      u_host.write(ACR_ADDR_DIAG, 8'hF0);
      rd_chk(ACR_ADDR_DIAG, 8'hF0);
      u_host.write(ACR_ADDR_OUT, 8'h80);
      $display("test write and read done");
   endtask
   task automatic t_indicator();
      u_host.write(ACR_ADDR_SWITCH, 8'h05);
      clip = 1'b1;
      repeat (8) @(negedge clk);
      check({7'h00, pin}, 8'h01);
      clip = 1'b0;
      u_host.write(ACR_ADDR_SWITCH, 8'h0D);
      der = 4'h2;
      repeat (8) @(negedge clk);
      check({7'h00, pin}, 8'h00);
      u_host.write(ACR_ADDR_SWITCH, 8'h8D);
      ovh = 4'hA;
      repeat (8) @(negedge clk);
      check({7'h00, pin}, 8'h01);
      rd_chk(ACR_ADDR_THERM, 8'hA2);
      $display("test indicator and thermal done");
   endtask
   task automatic t_probe_osc();
      u_host.write(ACR_ADDR_DIAG, 8'h51);
      settle(4'h1);
      check({4'h0, pa}, 8'h01);
      settle(4'h0);
      rd_chk(ACR_ADDR_DIAG, 8'h50);
      u_host.write(ACR_ADDR_DIAG, 8'h90);
      repeat (2) @(negedge clk);
      check({7'h00, oe}, 8'h01);
      u_host.write(ACR_ADDR_DIAG, 8'hD0);
      u_host.write(ACR_ADDR_SWITCH, 8'h4D);
      repeat (2) @(negedge clk);
      check({7'h00, oe}, 8'h00);
      $display("test probe and oscillator done");
   endtask
   task automatic t_freeze();
      u_host.write(ACR_ADDR_PAIR, 8'h00);
      ce = 1'b0;
      u_host.write(ACR_ADDR_PAIR, 8'h0F);
      ce = 1'b1;
      rd_chk(ACR_ADDR_PAIR, 8'h00);
      check({4'h0, gnd}, 8'h00);
      $display("test clock enable freeze done");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset_regs();
      t_write_read();
      t_reset_regs();
      t_indicator();
      t_probe_osc();
      t_freeze();
      give_verdict();
   end
   initial begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
